// ---- src/bit_op_pkg.sv ----
/*
  constants for the single-bit instruction execute unit: opcode fields,
  widths and phase encoding.
  assumes a 14-bit instruction word and a 7-bit file address.
*/
package bit_op_pkg;
    localparam int INSN_W = 14;
    localparam int ADDR_W = 7;
    localparam int BIDX_W = 3;
    localparam int DATA_W = 8;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_MSB = 6;
    localparam int BIDX_LSB = 7;
    localparam int BIDX_MSB = 9;
    localparam int SUB_LSB = 10;
    localparam int SUB_MSB = 11;
    localparam int GRP_LSB = 12;
    localparam int GRP_MSB = 13;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] SUB_CLR = 2'h0;
    localparam logic [1:0] SUB_SET = 2'h1;
    localparam logic [1:0] SUB_TSC = 2'h2;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;
    localparam logic [BIDX_W-1:0] BIDX_ZERO = 3'h0;
    localparam logic [DATA_W-1:0] ONE_HOT_LSB = 8'h01;
    // one-hot phase codes of an instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,
        PH_Q2 = 4'h2,
        PH_Q3 = 4'h4,
        PH_Q4 = 4'h8
    } phase_t;
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_CLR = 2'h1,
        OP_SET = 2'h2,
        OP_TSC = 2'h3
    } bit_op_t;
endpackage

// ---- src/bit_alu.sv ----
/*
  combinational bit modifier and tester for one data byte.
  assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_alu #(
    parameter int DATA_W = 8,
    parameter int BIDX_W = 3
) (
    // operands
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [BIDX_W-1:0] bidx_in,
    input wire logic set_in,
    // results
    output logic [DATA_W-1:0] data_set_out,
    output logic [DATA_W-1:0] data_clr_out,
    output logic bit_out
);
    logic [DATA_W-1:0] mask;
    always_comb begin
        mask = bit_op_pkg::ONE_HOT_LSB << bidx_in;
        data_set_out = data_in | mask;
        data_clr_out = data_in & ~mask;
        bit_out = data_in[bidx_in];
    end
    logic unused_set;
    assign unused_set = set_in;
endmodule
`default_nettype wire

// ---- src/bit_op_execute_unit.sv ----
/*
  decode and execute of the set-bit, clear-bit and test-skip-if-clear
  instructions as a four-phase read-modify-write on the data file.
  assumes the core presents a stable instruction during Q1 and a
  combinational file read port; writes land on the Q4 edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_op_execute_unit #(
    parameter int INSN_W = bit_op_pkg::INSN_W,
    parameter int ADDR_W = bit_op_pkg::ADDR_W,
    parameter int DATA_W = bit_op_pkg::DATA_W
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // instruction
    input wire logic [INSN_W-1:0] insn_in,
    input wire logic insn_valid_in,
    // file register port
    output logic [ADDR_W-1:0] file_addr_out,
    input wire logic [DATA_W-1:0] file_rdata_in,
    output logic [DATA_W-1:0] file_wdata_out,
    output logic file_we_out,
    // program counter control
    output logic skip_out,
    output logic busy_out
);
    localparam int BIDX_W = bit_op_pkg::BIDX_W;

    function automatic bit_op_pkg::bit_op_t decode_op(input logic [INSN_W-1:0] w);
        decode_op = bit_op_pkg::OP_NONE;
        if (w[bit_op_pkg::GRP_MSB:bit_op_pkg::GRP_LSB] == bit_op_pkg::GRP_BIT) begin
            if (w[bit_op_pkg::SUB_MSB:bit_op_pkg::SUB_LSB] == bit_op_pkg::SUB_SET) begin
                decode_op = bit_op_pkg::OP_SET;
            end else if (w[bit_op_pkg::SUB_MSB:bit_op_pkg::SUB_LSB] == bit_op_pkg::SUB_CLR) begin
                decode_op = bit_op_pkg::OP_CLR;
            end else if (w[bit_op_pkg::SUB_MSB:bit_op_pkg::SUB_LSB] == bit_op_pkg::SUB_TSC) begin
                decode_op = bit_op_pkg::OP_TSC;
            end
        end
    endfunction

    bit_op_pkg::phase_t phase_r, phase_nxt;
    bit_op_pkg::bit_op_t op_r, op_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [BIDX_W-1:0] bidx_r, bidx_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic we_r, we_nxt;
    logic skip_r, skip_nxt;
    logic bit_r, bit_nxt;
    logic [DATA_W-1:0] alu_set, alu_clr;
    logic alu_bit;

    bit_alu #(.DATA_W(DATA_W), .BIDX_W(BIDX_W)) u_alu (
        .data_in(data_r),
        .bidx_in(bidx_r),
        .set_in(op_r == bit_op_pkg::OP_SET),
        .data_set_out(alu_set),
        .data_clr_out(alu_clr),
        .bit_out(alu_bit)
    );

    always_comb begin
        phase_nxt = phase_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        bidx_nxt = bidx_r;
        data_nxt = data_r;
        wdata_nxt = wdata_r;
        we_nxt = 1'b0;
        skip_nxt = skip_r;
        bit_nxt = bit_r;
        case (phase_r)
            bit_op_pkg::PH_Q1: begin
                // a skipped slot decodes as a no-operation
                op_nxt = (insn_valid_in && !skip_r) ? decode_op(insn_in) : bit_op_pkg::OP_NONE;
                addr_nxt = insn_in[bit_op_pkg::ADDR_MSB:bit_op_pkg::ADDR_LSB];
                bidx_nxt = insn_in[bit_op_pkg::BIDX_MSB:bit_op_pkg::BIDX_LSB];
                skip_nxt = 1'b0;
                phase_nxt = bit_op_pkg::PH_Q2;
            end
            bit_op_pkg::PH_Q2: begin
                data_nxt = file_rdata_in;
                phase_nxt = bit_op_pkg::PH_Q3;
            end
            bit_op_pkg::PH_Q3: begin
                bit_nxt = alu_bit;
                if (op_r == bit_op_pkg::OP_SET) begin
                    wdata_nxt = alu_set;
                    we_nxt = 1'b1;
                end else if (op_r == bit_op_pkg::OP_CLR) begin
                    wdata_nxt = alu_clr;
                    we_nxt = 1'b1;
                end
                phase_nxt = bit_op_pkg::PH_Q4;
            end
            bit_op_pkg::PH_Q4: begin
                skip_nxt = (op_r == bit_op_pkg::OP_TSC) && !bit_r;
                phase_nxt = bit_op_pkg::PH_Q1;
            end
            default: begin
                phase_nxt = bit_op_pkg::PH_Q1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_r <= bit_op_pkg::PH_Q1;
            op_r <= bit_op_pkg::OP_NONE;
            addr_r <= bit_op_pkg::ADDR_ZERO;
            bidx_r <= bit_op_pkg::BIDX_ZERO;
            data_r <= bit_op_pkg::DATA_ZERO;
            wdata_r <= bit_op_pkg::DATA_ZERO;
            we_r <= 1'b0;
            skip_r <= 1'b0;
            bit_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            bidx_r <= bidx_nxt;
            data_r <= data_nxt;
            wdata_r <= wdata_nxt;
            we_r <= we_nxt;
            skip_r <= skip_nxt;
            bit_r <= bit_nxt;
        end
    end

    // only the addressed byte is written; no status flag output exists
    assign file_addr_out = addr_r;
    assign file_wdata_out = wdata_r;
    assign file_we_out = we_r;
    assign skip_out = skip_r;
    assign busy_out = (op_r != bit_op_pkg::OP_NONE);

    // read-modify-write checks
    a_set_one: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q3 && op_r == bit_op_pkg::OP_SET) |=>
        we_r && wdata_r[bidx_r] && ((wdata_r | (bit_op_pkg::ONE_HOT_LSB << bidx_r)) ==
        (data_r | (bit_op_pkg::ONE_HOT_LSB << bidx_r))))
        else $error("set bit wrong");
    a_clr_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q3 && op_r == bit_op_pkg::OP_CLR) |=>
        we_r && !wdata_r[bidx_r] && ((wdata_r & ~(bit_op_pkg::ONE_HOT_LSB << bidx_r)) ==
        (data_r & ~(bit_op_pkg::ONE_HOT_LSB << bidx_r))))
        else $error("clear bit wrong");
    a_data_take: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q2) |=> data_r == $past(file_rdata_in))
        else $error("read data not captured");
    a_we_pulse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        we_r |=> !we_r)
        else $error("write held too long");

    // decode and field checks
    a_field_take: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q1) |=>
        addr_r == $past(insn_in[bit_op_pkg::ADDR_MSB:bit_op_pkg::ADDR_LSB]) &&
        bidx_r == $past(insn_in[bit_op_pkg::BIDX_MSB:bit_op_pkg::BIDX_LSB]))
        else $error("fields not captured");
    a_addr_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r != bit_op_pkg::PH_Q1) |=> $stable(addr_r) && $stable(bidx_r))
        else $error("fields moved mid cycle");
    a_set_decode: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q1 && insn_valid_in && !skip_r &&
        insn_in[bit_op_pkg::GRP_MSB:bit_op_pkg::SUB_LSB] == {bit_op_pkg::GRP_BIT, bit_op_pkg::SUB_SET}) |=>
        op_r == bit_op_pkg::OP_SET)
        else $error("set not decoded");
    a_refuse_idle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q1 && !insn_valid_in) |=> op_r == bit_op_pkg::OP_NONE)
        else $error("invalid slot decoded");

    // write-port and phase checks
    a_write_only_q4: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        we_r |-> phase_r == bit_op_pkg::PH_Q4 && op_r != bit_op_pkg::OP_TSC)
        else $error("stray write");
    a_test_no_write: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q3 && op_r == bit_op_pkg::OP_TSC) |=> !we_r)
        else $error("test wrote the file");
    a_phase_ring: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q1) |=> phase_r == bit_op_pkg::PH_Q2 ##1
        phase_r == bit_op_pkg::PH_Q3 ##1 phase_r == bit_op_pkg::PH_Q4 ##1 phase_r == bit_op_pkg::PH_Q1)
        else $error("phase order broken");

    // skip flag stands through the Q1 that marks the discarded slot
    a_skip_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q3 && op_r == bit_op_pkg::OP_TSC && !alu_bit) |=> ##1 skip_r ##1 !skip_r)
        else $error("skip missing");
    a_no_skip_set: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q4 && !(op_r == bit_op_pkg::OP_TSC && !bit_r)) |=> !skip_r)
        else $error("false skip");
    a_skip_nop: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_r == bit_op_pkg::PH_Q1 && skip_r) |=> ##2 !we_r)
        else $error("skipped slot wrote");
    a_skip_q1_only: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        skip_r |-> phase_r == bit_op_pkg::PH_Q1)
        else $error("skip outside slot start");

    c_set: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        we_r && op_r == bit_op_pkg::OP_SET);
    c_clr: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        we_r && op_r == bit_op_pkg::OP_CLR);
    c_skip: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) $rose(skip_r));
    c_no_skip: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        phase_r == bit_op_pkg::PH_Q4 && op_r == bit_op_pkg::OP_TSC && bit_r);
    c_refused: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        phase_r == bit_op_pkg::PH_Q1 && insn_valid_in && decode_op(insn_in) == bit_op_pkg::OP_NONE);
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
/*
  self-checking bench for the single-bit instruction execute unit.
  assumes a combinational file model fed from file_addr_out and one
  instruction presented per four-clock instruction cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [13:0] insn_in = 14'h0000;
    logic insn_valid_in = 1'b0;
    logic [6:0] file_addr_out;
    logic [7:0] file_rdata_in;
    logic [7:0] file_wdata_out;
    logic file_we_out;
    logic skip_out;
    logic busy_out;
    logic [7:0] mem [128];
    logic [15:0] rnd = 16'h0012;
    logic skip_pend = 1'b0;
    int bad_count = 0;
    int checked = 0;

    assign file_rdata_in = mem[file_addr_out];
    always #10 sys_clk_in = ~sys_clk_in;

    bit_op_execute_unit dut_u (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .insn_in(insn_in),
        .insn_valid_in(insn_valid_in),
        .file_addr_out(file_addr_out),
        .file_rdata_in(file_rdata_in),
        .file_wdata_out(file_wdata_out),
        .file_we_out(file_we_out),
        .skip_out(skip_out),
        .busy_out(busy_out)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [7:0] modify(input logic [13:0] i, input logic [7:0] d);
        logic [7:0] m;
        m = 8'h01 << i[9:7];
        return (i[11:10] == 2'h1) ? (d | m) : (d & ~m);
    endfunction

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %b", $time, what, got);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one instruction cycle; returns 1 ns into the next Q1
    task automatic run(input logic [13:0] i, input logic v);
        logic live;
        logic wr;
        logic sk;
        logic [7:0] d;
        live = v && !skip_pend && i[13:12] == 2'h1 && i[11:10] != 2'h3;
        wr = live && i[11:10] != 2'h2;
        d = mem[i[6:0]];
        sk = live && i[11:10] == 2'h2 && !d[i[9:7]];
        insn_in = i;
        insn_valid_in = v;
        @(posedge sys_clk_in) #1;
        cmp_bit(busy_out, live, "busy");
        if (live) cmp_byte({1'b0, file_addr_out}, {1'b0, i[6:0]}, "address");
        repeat (2) @(posedge sys_clk_in) #1;
        cmp_bit(file_we_out, wr, "write enable");
        if (wr) begin
            cmp_byte(file_wdata_out, modify(i, d), "write data");
            mem[i[6:0]] = modify(i, d);
        end
        @(posedge sys_clk_in) #1;
        cmp_bit(skip_out, sk, "skip");
        skip_pend = sk;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        for (int a = 0; a < 128; a++) begin
            rnd = lfsr(rnd);
            mem[a] = rnd[7:0];
        end
        mem[127] = 8'h00;
        mem[0] = 8'hff;
        mem[5] = 8'h0a;
        repeat (16) @(posedge sys_clk_in);
        #1 sys_rst_in = 1'b0;
        cmp_bit(file_we_out, 1'b0, "write after reset");
        run(14'h17ff, 1'b1);
        run(14'h1000, 1'b1);
        run(14'h2005, 1'b1);
        run(14'h1785, 1'b1);
        run(14'h2085, 1'b1);
        run(14'h3085, 1'b1);
        run(14'h0485, 1'b1);
        run(14'h1485, 1'b0);
        repeat (300) begin
            rnd = lfsr(rnd);
            run({(rnd[15:14] == 2'h0) ? 2'h0 : 2'h1, rnd[11:0]}, |rnd[13:12]);
        end
        give_verdict();
    end

    // whole run is about 1250 clocks
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
